/* File: dv/spmr_lane_model.sv */
// behavioural lane model: cdr lock follows force bits, pcs counters clear on pulses
`timescale 1ns/1ps
module spmr_lane_model #(
    parameter int NUM_CH = 4
) (
    input  wire logic                                  clock,
    input  wire logic                                  sys_rst,
    input  wire logic [NUM_CH-1:0]                     force_lock_data,
    input  wire logic [NUM_CH-1:0]                     force_lock_ref,
    input  wire logic [NUM_CH-1:0]                     clr_blocks,
    input  wire logic [NUM_CH-1:0]                     clr_rate,
    input  wire logic [NUM_CH-1:0][7:0]                flags,
    output logic      [NUM_CH-1:0]                     cdr_data_locked,
    output logic      [NUM_CH-1:0]                     cdr_ref_locked,
    output spmr_pkg::spmr_pcs_stat_t [NUM_CH-1:0]      pcs_stat
);
    logic [NUM_CH-1:0][5:0] tally_r;
    logic [NUM_CH-1:0][7:0] blocks_r;
    // cdr settles one cycle after the force bits; reference lock wins when both are set
    always_ff @(posedge clock) begin
        cdr_data_locked <= force_lock_data & ~force_lock_ref;
        cdr_ref_locked  <= ~force_lock_data | force_lock_ref;
    end
    // counters start from a per-channel seed so that a wrong channel shows up
    always_ff @(posedge clock) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (sys_rst) begin
                tally_r[c]  <= 6'h20 + 6'(c);
                blocks_r[c] <= 8'h40 + 8'(c);
            end else begin
                if (clr_blocks[c]) blocks_r[c] <= 8'h00;
                if (clr_rate[c]) tally_r[c] <= 6'h00;
            end
        end
    end
    // flag bit n of the stimulus byte maps to status bit n
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            pcs_stat[c] = {flags[c][0], flags[c][1], flags[c][2], flags[c][3], flags[c][4],
                           flags[c][5], flags[c][6], flags[c][7], tally_r[c], blocks_r[c]};
        end
    end
endmodule

/* File: dv/spmr_regs_assertions.sv */
// concurrent checks on the ports of the phy management register bank
`timescale 1ns/1ps
`include "spmr_map.svh"
module spmr_regs_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic [8:0]        mgmt_addr,
    input wire logic [31:0]       mgmt_writedata,
    input wire logic              mgmt_write,
    input wire logic              mgmt_read,
    input wire logic [31:0]       mgmt_readdata,
    input wire logic              mgmt_waitrequest,
    input wire logic [NUM_CH-1:0] cdr_data_locked_in,
    input wire logic [NUM_CH-1:0] tx_digital_reset,
    input wire logic [NUM_CH-1:0] serial_loopback,
    input wire logic [NUM_CH-1:0] force_lock_data,
    input wire logic [NUM_CH-1:0] force_lock_ref,
    input wire logic [NUM_CH-1:0] clear_errored_block_counter,
    input wire logic [NUM_CH-1:0] clear_error_rate_counter,
    input wire logic              tx_ready,
    input wire logic              rx_ready
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic wr_ok;
    logic rd_ok;
    // an access counts only on an edge where waitrequest is low
    assign wr_ok = mgmt_write && !mgmt_waitrequest;
    assign rd_ok = mgmt_read && !mgmt_waitrequest;

    AST_WAIT_ONE: assert property ((wr_ok || rd_ok)
        |=> mgmt_waitrequest ##1 !mgmt_waitrequest)
        else $error("waitrequest not exactly one cycle");
    AST_TRIG_TX: assert property (wr_ok && mgmt_addr == `SPMR_ADDR_TRIG
        && mgmt_writedata[0] |-> ##[1:3] !tx_ready)
        else $error("tx trigger did not start a reset");
    AST_TRIG_RX: assert property (wr_ok && mgmt_addr == `SPMR_ADDR_TRIG
        && mgmt_writedata[1] |-> ##[1:24] !rx_ready)
        else $error("rx trigger did not start a reset");
    AST_SELF_CLR: assert property (wr_ok && mgmt_addr == `SPMR_ADDR_TRIG
        && mgmt_writedata[1] |-> ##[20:60] rx_ready)
        else $error("triggered reset never finished");
    AST_LOOPBACK: assert property (wr_ok && mgmt_addr == `SPMR_ADDR_LOOPBACK
        |-> ##2 serial_loopback == $past(mgmt_writedata[NUM_CH-1:0], 2)) else $error("loopback");
    AST_FORCE_DATA: assert property (wr_ok && mgmt_addr == `SPMR_ADDR_FORCE_DATA
        |-> ##2 force_lock_data == $past(mgmt_writedata[NUM_CH-1:0], 2)) else $error("data lock");
    AST_FORCE_REF: assert property (wr_ok && mgmt_addr == `SPMR_ADDR_FORCE_REF
        |-> ##2 force_lock_ref == $past(mgmt_writedata[NUM_CH-1:0], 2)) else $error("ref lock");
    AST_LOCK_READ: assert property (rd_ok && mgmt_addr == `SPMR_ADDR_DATA_LOCK
        |=> mgmt_readdata == 32'($past(cdr_data_locked_in))) else $error("lock status read");
    AST_SEL_READ: assert property (rd_ok && mgmt_addr == `SPMR_ADDR_CHAN_SEL
        |=> mgmt_readdata == `SPMR_ZERO32) else $error("channel select read not zero");
    AST_CLR_BLK: assert property (clear_errored_block_counter != '0
        |-> $onehot(clear_errored_block_counter) ##1 clear_errored_block_counter == '0)
        else $error("block clear not a single pulse");
    AST_CLR_RATE: assert property (clear_error_rate_counter != '0
        |-> $onehot(clear_error_rate_counter) ##1 clear_error_rate_counter == '0)
        else $error("rate clear not a single pulse");
    AST_RST_HOLD: assert property (disable iff (1'b0) $past(sys_rst) && sys_rst
        |-> tx_digital_reset == '1) else $error("tx reset not held in reset");

    cover property (wr_ok && mgmt_addr == `SPMR_ADDR_TRIG);
    cover property (rd_ok && mgmt_addr == `SPMR_ADDR_PCS_COUNTS);
    cover property (clear_error_rate_counter != '0);
endmodule

bind spmr_regs spmr_regs_chk #(.NUM_CH(NUM_CH)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_writedata(mgmt_writedata),
    .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_readdata(mgmt_readdata),
    .mgmt_waitrequest(mgmt_waitrequest), .cdr_data_locked_in(cdr_data_locked_in),
    .tx_digital_reset(tx_digital_reset), .serial_loopback(serial_loopback),
    .force_lock_data(force_lock_data), .force_lock_ref(force_lock_ref),
    .clear_errored_block_counter(clear_errored_block_counter),
    .clear_error_rate_counter(clear_error_rate_counter), .tx_ready(tx_ready), .rx_ready(rx_ready));

/* File: dv/tb_serial_phy_mgmt_registers.sv */
// self-checking bench for the phy management register bank
`timescale 1ns/1ps
`include "spmr_map.svh"
module tb_serial_phy_mgmt_registers;
    logic                           clock = 1'b0;
    logic                           sys_rst;
    logic                           mgmt_write;
    logic                           mgmt_read;
    logic                           mgmt_waitrequest;
    logic                           tx_ready;
    logic                           rx_ready;
    logic [8:0]                     mgmt_addr;
    logic [31:0]                    mgmt_writedata;
    logic [31:0]                    mgmt_readdata;
    logic [31:0]                    rd_val;
    logic [3:0]                     cdr_d;
    logic [3:0]                     cdr_r;
    logic [3:0]                     tx_dr;
    logic [3:0]                     rx_dr;
    logic [3:0]                     rx_ar;
    logic [3:0]                     loop_o;
    logic [3:0]                     fdat;
    logic [3:0]                     fref;
    logic [3:0]                     clr_b;
    logic [3:0]                     clr_r;
    logic [3:0][7:0]                flags;
    spmr_pkg::spmr_pcs_stat_t [3:0] stat;
    int                             fail_count = 0;
    int                             checked = 0;
    logic [8:0]                     mir_a [3] = '{`SPMR_ADDR_LOOPBACK, `SPMR_ADDR_FORCE_DATA,
                                                  `SPMR_ADDR_FORCE_REF};
    logic [31:0]                    mir_v [3] = '{32'h0000_0009, 32'h0000_0003, 32'h0000_0004};

    spmr_regs #(.NUM_CH(4)) dut (
        .clock(clock), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_writedata(mgmt_writedata),
        .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_readdata(mgmt_readdata),
        .mgmt_waitrequest(mgmt_waitrequest), .cdr_data_locked_in(cdr_d),
        .cdr_ref_locked_in(cdr_r), .pcs_stat_in(stat), .tx_digital_reset(tx_dr),
        .rx_digital_reset(rx_dr), .rx_analog_reset(rx_ar), .serial_loopback(loop_o),
        .force_lock_data(fdat), .force_lock_ref(fref), .clear_errored_block_counter(clr_b),
        .clear_error_rate_counter(clr_r), .tx_ready(tx_ready), .rx_ready(rx_ready));
    spmr_lane_model #(.NUM_CH(4)) u_lane (
        .clock(clock), .sys_rst(sys_rst), .force_lock_data(fdat), .force_lock_ref(fref),
        .clr_blocks(clr_b), .clr_rate(clr_r), .flags(flags), .cdr_data_locked(cdr_d),
        .cdr_ref_locked(cdr_r), .pcs_stat(stat));

    always #5 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held from a falling edge until the edge that takes it, released after
    task automatic access(input logic wr, input logic [8:0] a, input logic [31:0] d);
        @(negedge clock);
        mgmt_addr = a;
        mgmt_writedata = d;
        mgmt_write = wr;
        mgmt_read = !wr;
        while (mgmt_waitrequest) @(negedge clock);
        @(negedge clock);
        rd_val = mgmt_readdata;
        mgmt_write = 1'b0;
        mgmt_read = 1'b0;
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        access(1'b0, a, `SPMR_ZERO32);
        check(rd_val, exp);
    endtask
    task automatic final_report();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        final_report();
    end

    initial begin
        {sys_rst, mgmt_write, mgmt_read, mgmt_addr, mgmt_writedata} = {1'b1, 43'h0};
        flags = '0;
        repeat (8) @(negedge clock);
        check(32'(tx_dr), 32'h0000_000F);
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        repeat (60) @(negedge clock);
        rd_chk(`SPMR_ADDR_TRIG, 32'h0000_0003);
        rd_chk(`SPMR_ADDR_MASK, `SPMR_MASK_RESET);
        // triggered tx then rx reset, limited to channels 0 and 2
        access(1'b1, `SPMR_ADDR_MASK, 32'h0000_0005);
        access(1'b1, `SPMR_ADDR_TRIG, 32'h0000_0003);
        for (int i = 0; i < 8 && tx_dr === 4'h0; i++) @(negedge clock);
        check(32'({tx_ready, tx_dr}), 32'h0000_0005);
        for (int i = 0; i < 40 && rx_dr === 4'h0; i++) @(negedge clock);
        check(32'(rx_dr), 32'h0000_0005);
        repeat (40) @(negedge clock);
        check(32'({tx_dr, rx_dr}), `SPMR_ZERO32);
        rd_chk(`SPMR_ADDR_TRIG, 32'h0000_0003);
        // each manual field alone; reserved bits are written as zero
        for (int b = 1; b < 4; b++) begin
            access(1'b1, `SPMR_ADDR_MANUAL, 32'h0000_0001 << b);
            repeat (20) @(negedge clock);
            check(32'({rx_dr, rx_ar, tx_dr}), 32'h0000_0005 << (4*(b - 1)));
            rd_chk(`SPMR_ADDR_MANUAL, 32'h0000_0001 << b);
        end
        access(1'b1, `SPMR_ADDR_MANUAL, `SPMR_ZERO32);
        repeat (2) @(negedge clock);
        check(32'({rx_dr, rx_ar, tx_dr}), `SPMR_ZERO32);
        for (int i = 0; i < 3; i++) begin
            access(1'b1, mir_a[i], mir_v[i]);
            rd_chk(mir_a[i], mir_v[i]);
        end
        repeat (2) @(negedge clock);
        check(32'({fref, fdat, loop_o}), 32'h0000_0439);
        rd_chk(`SPMR_ADDR_DATA_LOCK, 32'h0000_0003);
        rd_chk(`SPMR_ADDR_REF_LOCK, 32'h0000_000C);
        access(1'b1, `SPMR_ADDR_DATA_LOCK, 32'h0000_000F);
        rd_chk(`SPMR_ADDR_DATA_LOCK, 32'h0000_0003);
        // indirect pcs status, counters and sticky flags
        flags[2] = 8'hA6;
        flags[1] = 8'h59;
        access(1'b1, `SPMR_ADDR_CHAN_SEL, 32'h0000_0002);
        rd_chk(`SPMR_ADDR_PCS_FLAGS, 32'h0000_00A6);
        access(1'b1, `SPMR_ADDR_CHAN_SEL, 32'h0000_0007);
        access(1'b1, `SPMR_ADDR_PCS_FLAGS, 32'h0000_00FF);
        rd_chk(`SPMR_ADDR_PCS_FLAGS, 32'h0000_00A6);
        rd_chk(`SPMR_ADDR_CHAN_SEL, `SPMR_ZERO32);
        rd_chk(`SPMR_ADDR_PCS_COUNTS, 32'h0000_D0A2);
        access(1'b1, `SPMR_ADDR_PCS_CLR, 32'h0000_0004);
        repeat (3) @(negedge clock);
        rd_chk(`SPMR_ADDR_PCS_COUNTS, 32'h0000_C022);
        access(1'b1, `SPMR_ADDR_PCS_CLR, 32'h0000_0008);
        repeat (3) @(negedge clock);
        rd_chk(`SPMR_ADDR_PCS_COUNTS, 32'h0000_C000);
        rd_chk(`SPMR_ADDR_PCS_CLR, `SPMR_ZERO32);
        flags[2] = 8'h00;
        rd_chk(`SPMR_ADDR_PCS_COUNTS, 32'h0000_C000);
        rd_chk(`SPMR_ADDR_PCS_COUNTS, `SPMR_ZERO32);
        access(1'b1, `SPMR_ADDR_CHAN_SEL, 32'h0000_0001);
        rd_chk(`SPMR_ADDR_PCS_FLAGS, 32'h0000_0059);
        rd_chk(`SPMR_ADDR_PCS_COUNTS, 32'h0000_1061);
        rd_chk(9'h1FF, `SPMR_ZERO32);
        // second reset in mid-run returns the bank to its reset state
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        check(32'(loop_o), `SPMR_ZERO32);
        repeat (60) @(negedge clock);
        rd_chk(`SPMR_ADDR_MASK, `SPMR_MASK_RESET);
        rd_chk(`SPMR_ADDR_TRIG, 32'h0000_0003);
        final_report();
    end
endmodule

/* File: pkg/spmr_map.svh */
// register offsets, field positions, reset values and timing counts of the phy management bank
`ifndef SPMR_MAP_SVH
`define SPMR_MAP_SVH

`define SPMR_ADDR_MASK       9'h041
`define SPMR_ADDR_TRIG       9'h042
`define SPMR_ADDR_MANUAL     9'h044
`define SPMR_ADDR_LOOPBACK   9'h061
`define SPMR_ADDR_FORCE_DATA 9'h064
`define SPMR_ADDR_FORCE_REF  9'h065
`define SPMR_ADDR_DATA_LOCK  9'h066
`define SPMR_ADDR_REF_LOCK   9'h067
`define SPMR_ADDR_CHAN_SEL   9'h080
`define SPMR_ADDR_PCS_CLR    9'h081
`define SPMR_ADDR_PCS_FLAGS  9'h082
`define SPMR_ADDR_PCS_COUNTS 9'h083

`define SPMR_TRIG_TX_BIT     0
`define SPMR_TRIG_RX_BIT     1
`define SPMR_MAN_TX_DIG_BIT  1
`define SPMR_MAN_RX_ANA_BIT  2
`define SPMR_MAN_RX_DIG_BIT  3
`define SPMR_CLR_ERRBLK_BIT  2
`define SPMR_CLR_RATE_BIT    3
`define SPMR_CNT_STICKY_HI   14
`define SPMR_CNT_STICKY_LOCK 15

`define SPMR_MASK_RESET      32'hFFFF_FFFF
`define SPMR_ZERO32          32'h0000_0000

// length of each automatic reset pulse in management clock cycles
`define SPMR_RESET_PULSE_CYC 8'h10

`endif

/* File: pkg/spmr_pkg.sv */
// types shared by the phy management register bank
package spmr_pkg;

    // reset sequencer phases
    typedef enum logic [1:0] {
        SPMR_SEQ_IDLE = 2'b00,
        SPMR_SEQ_TX   = 2'b01,
        SPMR_SEQ_RX   = 2'b10
    } spmr_seq_t;

    // per-channel pcs status as seen by the bank
    typedef struct packed {
        logic       link_up;
        logic       high_error_rate_flag;
        logic       block_lock;
        logic       tx_fifo_full;
        logic       rx_fifo_full;
        logic       sync_head_error;
        logic       descramble_error;
        logic       rx_data_ready;
        logic [5:0] error_rate_tally;
        logic [7:0] errored_blocks;
    } spmr_pcs_stat_t;

endpackage

/* File: verilog/spmr_regs.sv */
// phy management register bank: reset control, loopback, cdr lock and indirect pcs status
`timescale 1ns/1ps
`include "spmr_map.svh"
module spmr_regs #(
    parameter int NUM_CH = 4
) (
    input  wire logic                              clock,
    input  wire logic                              sys_rst,
    input  wire logic [8:0]                        mgmt_addr,
    input  wire logic [31:0]                       mgmt_writedata,
    input  wire logic                              mgmt_write,
    input  wire logic                              mgmt_read,
    output logic      [31:0]                       mgmt_readdata,
    output logic                                   mgmt_waitrequest,
    input  wire logic [NUM_CH-1:0]                 cdr_data_locked_in,
    input  wire logic [NUM_CH-1:0]                 cdr_ref_locked_in,
    input  wire spmr_pkg::spmr_pcs_stat_t [NUM_CH-1:0] pcs_stat_in,
    output logic      [NUM_CH-1:0]                 tx_digital_reset,
    output logic      [NUM_CH-1:0]                 rx_digital_reset,
    output logic      [NUM_CH-1:0]                 rx_analog_reset,
    output logic      [NUM_CH-1:0]                 serial_loopback,
    output logic      [NUM_CH-1:0]                 force_lock_data,
    output logic      [NUM_CH-1:0]                 force_lock_ref,
    output logic      [NUM_CH-1:0]                 clear_errored_block_counter,
    output logic      [NUM_CH-1:0]                 clear_error_rate_counter,
    output logic                                   tx_ready,
    output logic                                   rx_ready
);

    // refuse widths the registers cannot hold
    if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_num_ch
        $error("spmr_regs: NUM_CH must be 1 to 32");
    end

    // one select bit even for one channel
    localparam int SELW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // decoded strobes; the port answers in one cycle, and a request is taken on its first edge with waitrequest low
    logic                        wr_mask, wr_trig, wr_man, wr_loop, wr_fdata, wr_fref;
    logic                        wr_sel, wr_clr, rd_counts, accept;
    logic                        clr_blk_bit, clr_rate_bit;

    // stored fields
    logic [31:0]                 mask_r;
    logic [2:0]                  man_r;
    logic [NUM_CH-1:0]           loop_r, fdata_r, fref_r;
    logic [SELW-1:0]             sel_r;

    // sequencer
    logic [NUM_CH-1:0]           sticky_hi_r, sticky_lock_r;
    logic                        pend_tx_r, pend_rx_r;
    spmr_pkg::spmr_seq_t         seq_r;
    logic [7:0]                  seq_cnt_r;
    logic [NUM_CH-1:0]           seq_tx_rst_r, seq_rx_rst_r;

    // read path
    logic [NUM_CH-1:0]           chmask;
    spmr_pkg::spmr_pcs_stat_t    cur_stat;
    logic [31:0]                 rd_nxt;

    assign chmask  = mask_r[NUM_CH-1:0];
    assign cur_stat = pcs_stat_in[sel_r];

    // waitrequest is raised for the cycle after an accepted access so each one gets a slot
    assign accept  = (mgmt_write || mgmt_read) && !mgmt_waitrequest;
    assign wr_mask  = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_MASK;
    assign wr_trig  = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_TRIG;
    assign wr_man   = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_MANUAL;
    assign wr_loop  = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_LOOPBACK;
    assign wr_fdata = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_FORCE_DATA;
    assign wr_fref  = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_FORCE_REF;
    assign wr_sel   = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_CHAN_SEL;
    assign wr_clr   = accept && mgmt_write && mgmt_addr == `SPMR_ADDR_PCS_CLR;
    assign rd_counts = accept && mgmt_read && mgmt_addr == `SPMR_ADDR_PCS_COUNTS;

    // clear request bits
    assign clr_blk_bit  = mgmt_writedata[`SPMR_CLR_ERRBLK_BIT];
    assign clr_rate_bit = mgmt_writedata[`SPMR_CLR_RATE_BIT];

    // handshake: one wait cycle after every accepted access
    // low in reset: no stall after release
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mgmt_waitrequest <= 1'b0;
        end else begin
            mgmt_waitrequest <= accept;
        end
    end

    // channel reset mask, all channels enabled out of reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mask_r <= `SPMR_MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= mgmt_writedata;
        end
    end

    // manual reset fields; reserved bits are simply not stored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            man_r <= 3'b000;
        end else if (wr_man) begin
            man_r[0] <= mgmt_writedata[`SPMR_MAN_TX_DIG_BIT];
            man_r[1] <= mgmt_writedata[`SPMR_MAN_RX_ANA_BIT];
            man_r[2] <= mgmt_writedata[`SPMR_MAN_RX_DIG_BIT];
        end
    end

    // pma channel controls
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            loop_r  <= '0;
            fdata_r <= '0;
            fref_r  <= '0;
        end else begin
            if (wr_loop) begin
                loop_r <= mgmt_writedata[NUM_CH-1:0];
            end
            if (wr_fdata) begin
                fdata_r <= mgmt_writedata[NUM_CH-1:0];
            end
            if (wr_fref) begin
                fref_r <= mgmt_writedata[NUM_CH-1:0];
            end
        end
    end

    // indirect channel select; out-of-range numbers keep the old channel
    // write-only: software must track it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sel_r <= '0;
        end else if (wr_sel && mgmt_writedata < NUM_CH) begin
            sel_r <= mgmt_writedata[SELW-1:0];
        end
    end

    // trigger requests latch until the sequencer takes them, so the bits self-clear
    // a trigger during a pulse waits for idle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_tx_r <= 1'b0;
            pend_rx_r <= 1'b0;
        end else begin
            if (wr_trig && mgmt_writedata[`SPMR_TRIG_TX_BIT]) begin
                pend_tx_r <= 1'b1;
            end else if (seq_r == spmr_pkg::SPMR_SEQ_IDLE) begin
                pend_tx_r <= 1'b0;
            end
            if (wr_trig && mgmt_writedata[`SPMR_TRIG_RX_BIT]) begin
                pend_rx_r <= 1'b1;
            end else if (seq_r == spmr_pkg::SPMR_SEQ_IDLE && !pend_tx_r) begin
                pend_rx_r <= 1'b0;
            end
        end
    end

    // reset sequencer: tx pulse then rx pulse after reset, single pulses on trigger
    // ready bits stay low through their pulse
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            seq_r        <= spmr_pkg::SPMR_SEQ_TX;
            seq_cnt_r    <= `SPMR_RESET_PULSE_CYC;
            seq_tx_rst_r <= '1;
            seq_rx_rst_r <= '1;
            tx_ready     <= 1'b0;
            rx_ready     <= 1'b0;
        end else begin
            case (seq_r)
                spmr_pkg::SPMR_SEQ_IDLE: begin
                    // tx first when both were asked, rx follows from the held request
                    if (pend_tx_r) begin
                        seq_r        <= spmr_pkg::SPMR_SEQ_TX;
                        seq_cnt_r    <= `SPMR_RESET_PULSE_CYC;
                        seq_tx_rst_r <= chmask;
                        tx_ready     <= 1'b0;
                    end else if (pend_rx_r) begin
                        seq_r        <= spmr_pkg::SPMR_SEQ_RX;
                        seq_cnt_r    <= `SPMR_RESET_PULSE_CYC;
                        seq_rx_rst_r <= chmask;
                        rx_ready     <= 1'b0;
                    end
                end
                spmr_pkg::SPMR_SEQ_TX: begin
                    if (seq_cnt_r == 8'h01) begin
                        seq_tx_rst_r <= '0;
                        tx_ready     <= 1'b1;
                        seq_r        <= (seq_rx_rst_r != '0) ? spmr_pkg::SPMR_SEQ_RX
                                                             : spmr_pkg::SPMR_SEQ_IDLE;
                        seq_cnt_r    <= `SPMR_RESET_PULSE_CYC;
                    end else begin
                        seq_cnt_r <= seq_cnt_r - 8'h01;
                    end
                end
                spmr_pkg::SPMR_SEQ_RX: begin
                    if (seq_cnt_r == 8'h01) begin
                        seq_rx_rst_r <= '0;
                        rx_ready     <= 1'b1;
                        seq_r        <= spmr_pkg::SPMR_SEQ_IDLE;
                    end else begin
                        seq_cnt_r <= seq_cnt_r - 8'h01;
                    end
                end
                default: begin
                    seq_r <= spmr_pkg::SPMR_SEQ_IDLE;
                end
            endcase
        end
    end

    // reset outputs: sequencer pulses or manual holds, gated by the channel mask
    // mask applied live to manual holds; sequencer pulses take it when the trigger starts them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_digital_reset <= '1;
            rx_digital_reset <= '1;
            rx_analog_reset  <= '1;
        end else begin
            tx_digital_reset <= seq_tx_rst_r | ({NUM_CH{man_r[0]}} & chmask);
            rx_analog_reset  <= {NUM_CH{man_r[1]}} & chmask;
            rx_digital_reset <= seq_rx_rst_r | ({NUM_CH{man_r[2]}} & chmask);
        end
    end

    // registered pma controls and one-cycle pcs clear strobes to the selected channel
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_loopback             <= '0;
            force_lock_data             <= '0;
            force_lock_ref              <= '0;
            clear_errored_block_counter <= '0;
            clear_error_rate_counter    <= '0;
        end else begin
            serial_loopback             <= loop_r;
            force_lock_data             <= fdata_r;
            force_lock_ref              <= fref_r;
            clear_errored_block_counter <= '0;
            clear_error_rate_counter    <= '0;
            if (wr_clr) begin
                clear_errored_block_counter[sel_r] <= clr_blk_bit;
                clear_error_rate_counter[sel_r]    <= clr_rate_bit;
            end
        end
    end

    // sticky flags per channel; a new event in the read cycle wins over the clear
    // clear reaches the selected channel only
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_sticky
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    sticky_hi_r[g]   <= 1'b0;
                    sticky_lock_r[g] <= 1'b0;
                end else begin
                    if (pcs_stat_in[g].high_error_rate_flag) begin
                        sticky_hi_r[g] <= 1'b1;
                    end else if (rd_counts && sel_r == g) begin
                        sticky_hi_r[g] <= 1'b0;
                    end
                    if (pcs_stat_in[g].block_lock) begin
                        sticky_lock_r[g] <= 1'b1;
                    end else if (rd_counts && sel_r == g) begin
                        sticky_lock_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // read mux; write-only and unmapped words read zero
    always_comb begin
        rd_nxt = `SPMR_ZERO32;
        case (mgmt_addr)
            `SPMR_ADDR_MASK:       rd_nxt = mask_r;
            `SPMR_ADDR_TRIG:       rd_nxt = {30'h0, rx_ready, tx_ready};
            `SPMR_ADDR_MANUAL:     rd_nxt = {28'h0, man_r, 1'b0};
            `SPMR_ADDR_LOOPBACK:   rd_nxt[NUM_CH-1:0] = loop_r;
            `SPMR_ADDR_FORCE_DATA: rd_nxt[NUM_CH-1:0] = fdata_r;
            `SPMR_ADDR_FORCE_REF:  rd_nxt[NUM_CH-1:0] = fref_r;
            `SPMR_ADDR_DATA_LOCK:  rd_nxt[NUM_CH-1:0] = cdr_data_locked_in;
            `SPMR_ADDR_REF_LOCK:   rd_nxt[NUM_CH-1:0] = cdr_ref_locked_in;
            `SPMR_ADDR_CHAN_SEL:   rd_nxt = `SPMR_ZERO32;
            `SPMR_ADDR_PCS_FLAGS: begin
                rd_nxt[0] = cur_stat.link_up;
                rd_nxt[1] = cur_stat.high_error_rate_flag;
                rd_nxt[2] = cur_stat.block_lock;
                rd_nxt[3] = cur_stat.tx_fifo_full;
                rd_nxt[4] = cur_stat.rx_fifo_full;
                rd_nxt[5] = cur_stat.sync_head_error;
                rd_nxt[6] = cur_stat.descramble_error;
                rd_nxt[7] = cur_stat.rx_data_ready;
            end
            `SPMR_ADDR_PCS_COUNTS: begin
                rd_nxt[5:0]  = cur_stat.error_rate_tally;
                rd_nxt[13:6] = cur_stat.errored_blocks;
                rd_nxt[`SPMR_CNT_STICKY_HI]   = sticky_hi_r[sel_r];
                rd_nxt[`SPMR_CNT_STICKY_LOCK] = sticky_lock_r[sel_r];
            end
            default: rd_nxt = `SPMR_ZERO32;
        endcase
    end

    // read data registered on the accepting edge, held until the next read
    // holding the word keeps the bus quiet
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mgmt_readdata <= `SPMR_ZERO32;
        end else if (accept && mgmt_read) begin
            mgmt_readdata <= rd_nxt;
        end
    end

endmodule
